// *** src/sio_pkg.sv ***
package sio_pkg;
  // ----------------------------------------------------------------
  // Register map (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam logic [5:0] OFS_DIR = 6'h00;
  localparam logic [5:0] OFS_LEVEL = 6'h01;
  localparam logic [5:0] OFS_LATCH = 6'h02;
  localparam logic [5:0] OFS_ODC = 6'h03;
  localparam logic [5:0] OFS_ANA_CFG = 6'h04;
  localparam logic [5:0] OFS_CN_EN_LO = 6'h05;
  localparam logic [5:0] OFS_CN_EN_HI = 6'h06;
  localparam logic [5:0] OFS_PU_LO = 6'h07;
  localparam logic [5:0] OFS_PU_HI = 6'h08;
  localparam logic [5:0] OFS_CN_FLAG_LO = 6'h09;
  localparam logic [5:0] OFS_CN_FLAG_HI = 6'h0A;
  localparam logic [5:0] OFS_OSC_CTL = 6'h0B;
  localparam logic [5:0] OFS_IN_REMAP = 6'h10;
  localparam logic [5:0] OFS_OUT_REMAP = 6'h20;
  localparam int REGION_HI = 5;
  localparam int REGION_LO = 4;
  localparam int INDEX_W = 4;

  // ----------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------
  localparam logic [15:0] DIR_RST = 16'hFFFF;
  localparam logic [15:0] ANA_CFG_RST = 16'h0000;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h57;
  localparam int LOCK_BIT = 6;
  localparam int KEY_W = 8;
  localparam int SEL_W = 5;
  localparam logic [4:0] SEL_NULL = 5'h00;
  localparam int NFUNC = 32;
  localparam int CN_LO_W = 16;

  typedef enum logic [1:0] {
    SIO_UL_IDLE,
    SIO_UL_KEY1,
    SIO_UL_OPEN
  } sio_unlock_t;
endpackage : sio_pkg

// *** src/sio_port.sv ***
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module sio_port #(
  parameter int NPIN = 16,
  parameter int NRP = 16,
  parameter int NRIN = 15,
  parameter int NCN = 21,
  parameter logic [15:0] IMPL_MASK = 16'hFFFF,
  parameter logic [15:0] ANA_MASK = 16'h000F,
  parameter logic [15:0] IN_ONLY_MASK = 16'h0000,
  parameter bit IOL1WAY = 1'b0
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [sio_pkg::ADDR_W-1:0] ADDR,
  input wire logic [sio_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [sio_pkg::DATA_W-1:0] RDATA,
  input wire logic [NPIN-1:0] PIN_IN,
  output logic [NPIN-1:0] PIN_OUT,
  output logic [NPIN-1:0] PIN_OE,
  input wire logic [NPIN-1:0] PERIPH_EN,
  input wire logic [NPIN-1:0] PERIPH_DRIVE,
  input wire logic [NPIN-1:0] PERIPH_OUT,
  output logic [NPIN-1:0] PERIPH_IN,
  input wire logic [sio_pkg::NFUNC-1:0] RMP_FUNC_OUT,
  input wire logic [sio_pkg::NFUNC-1:0] RMP_FUNC_OE,
  output logic [NRIN-1:0] RMP_FUNC_IN,
  input wire logic [NCN-1:0] CN_PIN,
  output logic [NCN-1:0] PULLUP_EN,
  output logic CN_IRQ,
  input wire logic SLEEP,
  output logic WAKE_REQ
);
  // Notification inputs past the low sixteen sit in the high registers
  localparam int HI_W = NCN - sio_pkg::CN_LO_W;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [NPIN-1:0] dir_ff;
  logic [NPIN-1:0] latch_ff;
  logic [NPIN-1:0] odc_ff;
  logic [NPIN-1:0] ana_ff;
  logic [NCN-1:0] cn_en_ff;
  logic [NCN-1:0] pu_ff;
  logic [NCN-1:0] cn_flag_ff;
  logic [NCN-1:0] cn_s1_ff;
  logic [NCN-1:0] cn_s2_ff;
  logic [NCN-1:0] cn_prev_ff;
  logic [NCN-1:0] cn_snap_ff;
  logic lock_ff;
  sio_pkg::sio_unlock_t ul_ff;
  logic [sio_pkg::SEL_W-1:0] in_sel_ff [NRIN];
  logic [sio_pkg::SEL_W-1:0] out_sel_ff [NRP];
  logic [sio_pkg::DATA_W-1:0] rdata_ff;
  logic [NPIN-1:0] pin_out_ff;
  logic [NPIN-1:0] pin_oe_ff;
  logic [NPIN-1:0] periph_in_ff;
  logic [NRIN-1:0] rmp_in_ff;
  logic irq_ff;
  logic wake_ff;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic in_region;
  logic out_region;
  logic [sio_pkg::INDEX_W-1:0] idx;
  logic osc_wr;
  logic remap_ok;
  logic [NPIN-1:0] wmask;
  assign wr_en = WR & CE;
  assign rd_en = RD & CE;
  assign idx = ADDR[sio_pkg::INDEX_W-1:0];
  assign in_region = ADDR[sio_pkg::REGION_HI:sio_pkg::REGION_LO] ==
    sio_pkg::OFS_IN_REMAP[sio_pkg::REGION_HI:sio_pkg::REGION_LO];
  assign out_region = ADDR[sio_pkg::REGION_HI:sio_pkg::REGION_LO] ==
    sio_pkg::OFS_OUT_REMAP[sio_pkg::REGION_HI:sio_pkg::REGION_LO];
  assign osc_wr = wr_en & (ADDR == sio_pkg::OFS_OSC_CTL);
  // Locked remap writes look normal but change nothing
  assign remap_ok = wr_en & ~lock_ff;
  // Missing bits never take a write
  assign wmask = IMPL_MASK[NPIN-1:0];

  // ----------------------------------------------------------------
  // Pin ownership and drive
  // ----------------------------------------------------------------
  logic [NPIN-1:0] own_periph;
  logic [NPIN-1:0] own_data;
  logic [NPIN-1:0] port_drv;
  logic [NPIN-1:0] drv_data;
  logic [NPIN-1:0] drv_any;
  logic [NPIN-1:0] nxt_oe;
  logic [NPIN-1:0] nxt_out;
  logic [NPIN-1:0] level;
  logic [NPIN-1:0] nxt_periph_in;

  // One slice per pin; remap muxes exist only on remappable pins
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      logic rmp_on;
      logic rmp_oe;
      logic rmp_dat;
      if (gi < NRP) begin : g_rmp
        // Non-null code hands the pin to the selected function
        assign rmp_on = out_sel_ff[gi] != sio_pkg::SEL_NULL;
        assign rmp_oe = RMP_FUNC_OE[out_sel_ff[gi]];
        assign rmp_dat = RMP_FUNC_OUT[out_sel_ff[gi]];
      end else begin : g_fix
        assign rmp_on = 1'b0;
        assign rmp_oe = 1'b0;
        assign rmp_dat = 1'b0;
      end
      // Peripheral owns the driver only while it actively drives
      assign own_periph[gi] = IMPL_MASK[gi] & ~IN_ONLY_MASK[gi] &
        (rmp_on ? rmp_oe : PERIPH_EN[gi] & PERIPH_DRIVE[gi]);
      assign own_data[gi] = rmp_on ? rmp_dat : PERIPH_OUT[gi];
      // Direction bit low makes the port drive
      assign port_drv[gi] = IMPL_MASK[gi] & ~dir_ff[gi] &
        ~own_periph[gi];
      assign drv_any[gi] = own_periph[gi] | port_drv[gi];
      assign drv_data[gi] = own_periph[gi] ? own_data[gi]
        : latch_ff[gi];
      // Open drain: enable only when pulling low
      assign nxt_oe[gi] = drv_any[gi] &
        (~odc_ff[gi] | ~drv_data[gi]);
      assign nxt_out[gi] = drv_data[gi] & ~odc_ff[gi];
      // A port-driven pin feeds nothing back to its peripheral
      assign nxt_periph_in[gi] = ~port_drv[gi] & PIN_IN[gi];
    end
  endgenerate

  // Analog pins and missing bits read low
  assign level = PIN_IN & wmask & ~(ANA_MASK[NPIN-1:0] & ~ana_ff);

  // ----------------------------------------------------------------
  // Remapped peripheral inputs
  // ----------------------------------------------------------------
  logic [NRIN-1:0] nxt_rmp_in;
  generate
    for (gi = 0; gi < NRIN; gi++) begin : g_rin
      // Selector value names the remappable pin; out of range reads 0
      assign nxt_rmp_in[gi] = (int'(in_sel_ff[gi]) < NRP) &
        PIN_IN[in_sel_ff[gi][sio_pkg::INDEX_W-1:0]];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Change notification
  // ----------------------------------------------------------------
  logic [NCN-1:0] cn_change;
  logic [NCN-1:0] cn_clr;
  logic [NCN-1:0] nxt_flag;
  logic [NCN-1:0] cn_wake;
  assign cn_change = (cn_s2_ff ^ cn_prev_ff) & cn_en_ff;
  // Write-one-to-clear masks, high half on the left
  assign cn_clr = {
    (wr_en & ADDR == sio_pkg::OFS_CN_FLAG_HI) ? WDATA[HI_W-1:0]
      : {HI_W{1'b0}},
    (wr_en & ADDR == sio_pkg::OFS_CN_FLAG_LO) ? WDATA
      : sio_pkg::ZERO16};
  // New change beats a clear in the same cycle
  assign nxt_flag = (cn_flag_ff & ~cn_clr) | cn_change;
  // Asleep, compare against the level held at sleep entry
  assign cn_wake = (cn_s2_ff ^ cn_snap_ff) & cn_en_ff;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [sio_pkg::DATA_W-1:0] rd_val;
  logic [sio_pkg::DATA_W-1:0] in_rd;
  logic [sio_pkg::DATA_W-1:0] out_rd;
  // Slots past either selector array read as zero
  assign in_rd = (int'(idx) < NRIN) ?
    {{(sio_pkg::DATA_W-sio_pkg::SEL_W){1'b0}}, in_sel_ff[idx]}
    : sio_pkg::ZERO16;
  assign out_rd = (int'(idx) < NRP) ?
    {{(sio_pkg::DATA_W-sio_pkg::SEL_W){1'b0}}, out_sel_ff[idx]}
    : sio_pkg::ZERO16;
  // Offsets never overlap, so the chain order does not matter
  assign rd_val =
    (ADDR == sio_pkg::OFS_DIR) ? dir_ff & wmask :
    (ADDR == sio_pkg::OFS_LEVEL) ? level :
    (ADDR == sio_pkg::OFS_LATCH) ? latch_ff & wmask :
    (ADDR == sio_pkg::OFS_ODC) ? odc_ff :
    (ADDR == sio_pkg::OFS_ANA_CFG) ? ana_ff :
    (ADDR == sio_pkg::OFS_CN_EN_LO) ? cn_en_ff[sio_pkg::CN_LO_W-1:0] :
    (ADDR == sio_pkg::OFS_CN_EN_HI) ?
      {{(sio_pkg::DATA_W-HI_W){1'b0}}, cn_en_ff[NCN-1:sio_pkg::CN_LO_W]} :
    (ADDR == sio_pkg::OFS_PU_LO) ? pu_ff[sio_pkg::CN_LO_W-1:0] :
    (ADDR == sio_pkg::OFS_PU_HI) ?
      {{(sio_pkg::DATA_W-HI_W){1'b0}}, pu_ff[NCN-1:sio_pkg::CN_LO_W]} :
    (ADDR == sio_pkg::OFS_CN_FLAG_LO) ?
      cn_flag_ff[sio_pkg::CN_LO_W-1:0] :
    (ADDR == sio_pkg::OFS_CN_FLAG_HI) ?
      {{(sio_pkg::DATA_W-HI_W){1'b0}},
       cn_flag_ff[NCN-1:sio_pkg::CN_LO_W]} :
    (ADDR == sio_pkg::OFS_OSC_CTL) ?
      sio_pkg::DATA_W'(lock_ff) << sio_pkg::LOCK_BIT :
    in_region ? in_rd :
    out_region ? out_rd : sio_pkg::ZERO16;

  // ----------------------------------------------------------------
  // Port configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dir_ff <= sio_pkg::DIR_RST;
      latch_ff <= sio_pkg::ZERO16;
      odc_ff <= sio_pkg::ZERO16;
      ana_ff <= sio_pkg::ANA_CFG_RST;
    end else if (wr_en) begin
      // Missing pins stay inputs, so they can never drive
      if (ADDR == sio_pkg::OFS_DIR) dir_ff <= WDATA | ~wmask;
      if (ADDR == sio_pkg::OFS_LATCH || ADDR == sio_pkg::OFS_LEVEL)
        latch_ff <= WDATA & wmask;
      if (ADDR == sio_pkg::OFS_ODC) odc_ff <= WDATA & wmask;
      if (ADDR == sio_pkg::OFS_ANA_CFG)
        ana_ff <= WDATA & ANA_MASK[NPIN-1:0];
    end
  end

  // Notification enables and pull-ups, split low and high halves
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cn_en_ff <= '0;
      pu_ff <= '0;
    end else if (wr_en) begin
      if (ADDR == sio_pkg::OFS_CN_EN_LO)
        cn_en_ff[sio_pkg::CN_LO_W-1:0] <= WDATA;
      if (ADDR == sio_pkg::OFS_CN_EN_HI)
        cn_en_ff[NCN-1:sio_pkg::CN_LO_W] <= WDATA[HI_W-1:0];
      if (ADDR == sio_pkg::OFS_PU_LO)
        pu_ff[sio_pkg::CN_LO_W-1:0] <= WDATA;
      if (ADDR == sio_pkg::OFS_PU_HI)
        pu_ff[NCN-1:sio_pkg::CN_LO_W] <= WDATA[HI_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Remap lock: two-key sequence then one lock write
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ul_ff <= sio_pkg::SIO_UL_IDLE;
      lock_ff <= 1'b0;
    end else if (osc_wr) begin
      case (ul_ff)
        sio_pkg::SIO_UL_OPEN: begin
          // One-way option keeps a set lock until reset
          lock_ff <= WDATA[sio_pkg::LOCK_BIT] | (IOL1WAY & lock_ff);
          ul_ff <= sio_pkg::SIO_UL_IDLE;
        end
        // Second key counts only right after the first
        sio_pkg::SIO_UL_KEY1: begin
          ul_ff <= (WDATA[sio_pkg::KEY_W-1:0] == sio_pkg::UNLOCK_KEY2) ?
            sio_pkg::SIO_UL_OPEN : sio_pkg::SIO_UL_IDLE;
        end
        // Any other value restarts the key sequence
        default: begin
          ul_ff <= (WDATA[sio_pkg::KEY_W-1:0] == sio_pkg::UNLOCK_KEY1) ?
            sio_pkg::SIO_UL_KEY1 : sio_pkg::SIO_UL_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Remap selectors, held in small arrays
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < NRIN; i++) in_sel_ff[i] <= sio_pkg::SEL_NULL;
      for (int i = 0; i < NRP; i++) out_sel_ff[i] <= sio_pkg::SEL_NULL;
    end else if (remap_ok) begin
      if (in_region && int'(idx) < NRIN)
        in_sel_ff[idx] <= WDATA[sio_pkg::SEL_W-1:0];
      if (out_region && int'(idx) < NRP)
        out_sel_ff[idx] <= WDATA[sio_pkg::SEL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Change detect pipeline and sticky flags
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cn_s1_ff <= '0;
      cn_s2_ff <= '0;
      cn_prev_ff <= '0;
      cn_snap_ff <= '0;
      cn_flag_ff <= '0;
    end else if (CE) begin
      cn_s1_ff <= CN_PIN;
      cn_s2_ff <= cn_s1_ff;
      cn_prev_ff <= cn_s2_ff;
      // Snapshot freezes on sleep entry
      if (!SLEEP) cn_snap_ff <= cn_s2_ff;
      // Flags are sticky until software writes a one
      cn_flag_ff <= nxt_flag;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_ff <= sio_pkg::ZERO16;
      pin_out_ff <= '0;
      pin_oe_ff <= '0;
      periph_in_ff <= '0;
      rmp_in_ff <= '0;
      irq_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else if (CE) begin
      // Read data stands for exactly one cycle
      rdata_ff <= rd_en ? rd_val : sio_pkg::ZERO16;
      pin_out_ff <= nxt_out;
      pin_oe_ff <= nxt_oe;
      periph_in_ff <= nxt_periph_in;
      rmp_in_ff <= nxt_rmp_in;
      irq_ff <= |nxt_flag;
      wake_ff <= SLEEP & |cn_wake;
    end
  end

  // ----------------------------------------------------------------
  // Top-level outputs, each straight from a flip-flop
  // ----------------------------------------------------------------
  assign RDATA = rdata_ff;
  assign PIN_OUT = pin_out_ff;
  assign PIN_OE = pin_oe_ff;
  assign PERIPH_IN = periph_in_ff;
  assign RMP_FUNC_IN = rmp_in_ff;
  // Pull-ups need no extra stage; the register drives them
  assign PULLUP_EN = pu_ff;
  assign CN_IRQ = irq_ff;
  assign WAKE_REQ = wake_ff;
endmodule : sio_port

// *** test/sio_props.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port-level checks on the shared I/O port
// ----------------------------------------------------------------
module sio_props #(
  parameter int NPIN = 16,
  parameter int NCN = 21
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic [NPIN-1:0] PIN_OE,
  input wire logic [NPIN-1:0] PIN_OUT,
  input wire logic [NPIN-1:0] PERIPH_EN,
  input wire logic [NPIN-1:0] PERIPH_DRIVE,
  input wire logic [NPIN-1:0] PERIPH_OUT,
  input wire logic [31:0] RMP_FUNC_OE,
  input wire logic [NCN-1:0] CN_PIN,
  input wire logic [NCN-1:0] PULLUP_EN,
  input wire logic CN_IRQ,
  input wire logic SLEEP,
  input wire logic WAKE_REQ
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  // Pin 3 is never remapped by the bench, so the peripheral owns it
  property p_periph_owns;
    CE && PERIPH_EN[3] && PERIPH_DRIVE[3] |=>
      PIN_OE[3] && PIN_OUT[3] == $past(PERIPH_OUT[3]);
  endproperty
  a_periph_owns: assert property (p_periph_owns)
    else $error("peripheral does not own pin 3");

  property p_rdata_idle;
    CE && !RD |=> RDATA == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read slot");

  // Sync takes two edges, so a new flag points back 2 to 5 edges
  property p_irq_cause;
    $rose(CN_IRQ) |-> ($past(CN_PIN, 2) != $past(CN_PIN, 3)) ||
      ($past(CN_PIN, 3) != $past(CN_PIN, 4)) ||
      ($past(CN_PIN, 4) != $past(CN_PIN, 5));
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("change request without an input change");

  property p_irq_hold;
    CN_IRQ && !WR |=> CN_IRQ;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("change request dropped without a clear");

  property p_wake_sleep;
    WAKE_REQ |-> $past(SLEEP) || $past(SLEEP, 2);
  endproperty
  a_wake_sleep: assert property (p_wake_sleep)
    else $error("wake request outside sleep");

  property p_oe_cause;
    $rose(PIN_OE[0]) |-> $past(WR) || $past(WR, 2) ||
      $past(PERIPH_EN[0]) || $past(|RMP_FUNC_OE);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("pin 0 driver enabled with no cause");

  property p_pullup_cause;
    $changed(PULLUP_EN) |-> $past(WR) || $past(WR, 2);
  endproperty
  a_pullup_cause: assert property (p_pullup_cause)
    else $error("pull-up enables moved without a write");

  property p_reset_in;
    !$past(RST_N) |-> PIN_OE == '0;
  endproperty
  a_reset_in: assert property (p_reset_in)
    else $error("pin driven right after reset");
endmodule : sio_props

bind sio_port sio_props #(.NPIN(NPIN), .NCN(NCN)) u_props (.CLK(CLK),
  .RST_N(RST_N), .CE(CE), .WR(WR), .RD(RD), .RDATA(RDATA),
  .PIN_OE(PIN_OE), .PIN_OUT(PIN_OUT), .PERIPH_EN(PERIPH_EN),
  .PERIPH_DRIVE(PERIPH_DRIVE), .PERIPH_OUT(PERIPH_OUT),
  .RMP_FUNC_OE(RMP_FUNC_OE), .CN_PIN(CN_PIN), .PULLUP_EN(PULLUP_EN),
  .CN_IRQ(CN_IRQ), .SLEEP(SLEEP), .WAKE_REQ(WAKE_REQ));

// *** test/sio_pins_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Board side: pins, external drivers and notification lines
// ----------------------------------------------------------------
module sio_pins_model #(
  parameter int NPIN = 16,
  parameter int NCN = 21
) (
  input wire logic clk,
  input wire logic [NPIN-1:0] pin_oe,
  input wire logic [NPIN-1:0] pin_out,
  input wire logic [NPIN-1:0] ext_val,
  output logic [NPIN-1:0] pin_in,
  input wire logic [NCN-1:0] cn_oe,
  input wire logic [NCN-1:0] cn_val,
  input wire logic [NCN-1:0] pullup_en,
  output logic [NCN-1:0] cn_pin
);
  logic float_ff = 1'b0;

  // Undriven line with no pull-up wanders, so X never settles to 0
  always_ff @(posedge clk) begin
    float_ff <= !float_ff;
  end

  // A released pin, open-drain high included, shows the external level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
  assign cn_pin = (cn_oe & cn_val) |
    (~cn_oe & (pullup_en | {NCN{float_ff}}));
endmodule : sio_pins_model

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] IMPL = 16'h7FFF;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata, pin_in, pin_out, pin_oe, periph_in, rv;
  logic [15:0] ext_val = 16'hDA0F;
  logic [15:0] p_en = 16'h0000, p_drv = 16'h0000, p_out = 16'h0000;
  logic [31:0] f_out = 32'h00000000, f_oe = 32'h00000000;
  logic [14:0] rmp_in;
  logic [20:0] cn_oe = 21'h1FFFFF, cn_val = 21'h000000, cn_pin, pu_en;
  logic irq, wake;
  logic sleep = 1'b0;
  logic ce = 1'b1;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;

  // Clock is free running; CE drops only in the hold scenario
  always #4 clk = ~clk;

  sio_port #(.IMPL_MASK(IMPL)) dut (.CLK(clk), .RST_N(rst_n), .CE(ce),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .PERIPH_EN(p_en), .PERIPH_DRIVE(p_drv), .PERIPH_OUT(p_out),
    .PERIPH_IN(periph_in), .RMP_FUNC_OUT(f_out), .RMP_FUNC_OE(f_oe),
    .RMP_FUNC_IN(rmp_in), .CN_PIN(cn_pin), .PULLUP_EN(pu_en),
    .CN_IRQ(irq), .SLEEP(sleep), .WAKE_REQ(wake));

  sio_pins_model pins (.clk(clk), .pin_oe(pin_oe), .pin_out(pin_out),
    .ext_val(ext_val), .pin_in(pin_in), .cn_oe(cn_oe), .cn_val(cn_val),
    .pullup_en(pu_en), .cn_pin(cn_pin));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // Run takes about 150 cycles; anything far past that is a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails = fails + 1;
      give_verdict();
    end
  end

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wreg(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input string n, input logic [5:0] a,
                      input logic [15:0] m, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
    chk(n, e, rv & m);
  endtask : rchk

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    wait_n(1);
    chk("oe", 16'h0000, pin_oe);
    rchk("dir", sio_pkg::OFS_DIR, 16'hFFFF, 16'h7FFF);
    rchk("ana", sio_pkg::OFS_ANA_CFG, 16'hFFFF, 16'h0000);
    rchk("hole", 6'h3F, 16'hFFFF, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_port;
    wreg(sio_pkg::OFS_LATCH, 16'h00A5);
    rchk("lat", sio_pkg::OFS_LATCH, 16'hFFFF, 16'h00A5);
    wreg(sio_pkg::OFS_DIR, 16'hFF0F);
    wait_n(2);
    chk("oe", 16'h00F0, pin_oe);
    chk("out", 16'h00A0, pin_out & 16'h00F0);
    rchk("lvl", sio_pkg::OFS_LEVEL, 16'hFFFF, 16'h5AA0);
    wreg(sio_pkg::OFS_ANA_CFG, 16'h000F);
    rchk("dig", sio_pkg::OFS_LEVEL, 16'hFFFF, 16'h5AAF);
    wreg(sio_pkg::OFS_DIR, 16'hFF00);
    wreg(sio_pkg::OFS_LEVEL, 16'h0033);
    rchk("lat2", sio_pkg::OFS_LATCH, 16'hFFFF, 16'h0033);
    chk("out2", 16'h0033, pin_out & 16'h00FF);
    rchk("dir2", sio_pkg::OFS_DIR, 16'hFFFF, 16'h7F00);
    $display("test port done");
  endtask : t_port

  task automatic t_periph;
    @(posedge clk);
    p_en <= 16'h0008;
    p_drv <= 16'h0008;
    p_out <= 16'h0008;
    wait_n(2);
    chk("p_oe", 16'h0008, pin_oe & 16'h0008);
    chk("p_out", 16'h0008, pin_out & 16'h0008);
    rchk("p_lvl", sio_pkg::OFS_LEVEL, 16'hFFFF, 16'h5A3B);
    @(posedge clk);
    p_drv <= 16'h0000;
    p_out <= 16'h0000;
    wreg(sio_pkg::OFS_LATCH, 16'h003B);
    wait_n(2);
    chk("port", 16'h0008, pin_oe & pin_out & 16'h0008);
    chk("loop", 16'h0000, periph_in & 16'h0008);
    @(posedge clk);
    p_en <= 16'h0000;
    $display("test periph done");
  endtask : t_periph

  task automatic t_odc;
    wreg(sio_pkg::OFS_ODC, 16'h0001);
    wait_n(2);
    chk("od_hi", 16'h0000, pin_oe & 16'h0001);
    wreg(sio_pkg::OFS_LATCH, 16'h0032);
    wait_n(2);
    chk("od_lo", 16'h0001, pin_oe & 16'h0001);
    chk("od_out", 16'h0000, pin_out & 16'h0001);
    $display("test odc done");
  endtask : t_odc

  task automatic t_cn;
    wreg(sio_pkg::OFS_CN_EN_LO, 16'h0001);
    wreg(sio_pkg::OFS_CN_EN_HI, 16'h0010);
    @(posedge clk);
    cn_val <= 21'h000002;
    wait_n(6);
    chk("cn_off", 16'h0000, 16'(irq));
    @(posedge clk);
    cn_val <= 21'h000003;
    wait_n(4);
    chk("irq", 16'h0001, 16'(irq));
    rchk("f_lo", sio_pkg::OFS_CN_FLAG_LO, 16'hFFFF, 16'h0001);
    wreg(sio_pkg::OFS_CN_FLAG_LO, 16'h0001);
    wait_n(1);
    chk("irq_clr", 16'h0000, 16'(irq));
    @(posedge clk);
    cn_val <= 21'h100003;
    wait_n(4);
    rchk("f_hi", sio_pkg::OFS_CN_FLAG_HI, 16'hFFFF, 16'h0010);
    wreg(sio_pkg::OFS_CN_FLAG_HI, 16'h0010);
    $display("test notify done");
  endtask : t_cn

  task automatic t_pullup;
    @(posedge clk);
    cn_oe <= 21'h1FFFFB;
    wreg(sio_pkg::OFS_PU_LO, 16'h0004);
    wreg(sio_pkg::OFS_PU_HI, 16'h0010);
    wait_n(2);
    chk("pu_lo", 16'h0004, 16'(pu_en));
    chk("pu_hi", 16'h0010, 16'(pu_en >> 16));
    chk("pu_pin", 16'h0001, 16'(cn_pin[2]));
    $display("test pullup done");
  endtask : t_pullup

  task automatic t_sleep;
    @(posedge clk);
    sleep <= 1'b1;
    wait_n(4);
    @(posedge clk);
    cn_val <= 21'h100002;
    wait_n(6);
    chk("wake", 16'h0001, 16'(wake));
    @(posedge clk);
    sleep <= 1'b0;
    wait_n(2);
    chk("wake_off", 16'h0000, 16'(wake));
    wreg(sio_pkg::OFS_CN_FLAG_LO, 16'h0001);
    $display("test sleep done");
  endtask : t_sleep

  task automatic t_remap;
    @(posedge clk);
    f_oe <= 32'h00000008;
    wreg(sio_pkg::OFS_OUT_REMAP + 6'h05, 16'h0003);
    wreg(sio_pkg::OFS_IN_REMAP, 16'h0009);
    wait_n(3);
    chk("rmp_oe", 16'h0020, pin_oe & 16'h0020);
    chk("rmp_out", 16'h0000, pin_out & 16'h0020);
    chk("rmp_in", 16'h0001, 16'(rmp_in[0]));
    wreg(sio_pkg::OFS_OSC_CTL, 16'h0046);
    wreg(sio_pkg::OFS_OSC_CTL, 16'h0057);
    wreg(sio_pkg::OFS_OSC_CTL, 16'h0040);
    rchk("lock", sio_pkg::OFS_OSC_CTL, 16'h0040, 16'h0040);
    wreg(sio_pkg::OFS_OUT_REMAP + 6'h05, 16'h0000);
    rchk("held", sio_pkg::OFS_OUT_REMAP + 6'h05, 16'h001F,
         16'h0003);
    wreg(sio_pkg::OFS_OSC_CTL, 16'h0046);
    wreg(sio_pkg::OFS_OSC_CTL, 16'h0057);
    wreg(sio_pkg::OFS_OSC_CTL, 16'h0000);
    wreg(sio_pkg::OFS_OUT_REMAP + 6'h05, 16'h0000);
    wait_n(3);
    chk("null", 16'h0020, pin_out & 16'h0020);
    $display("test remap done");
  endtask : t_remap

  // A write while CE is low must leave the latch untouched
  task automatic t_hold;
    @(posedge clk);
    ce <= 1'b0;
    wreg(sio_pkg::OFS_LATCH, 16'h00FF);
    @(posedge clk);
    ce <= 1'b1;
    rchk("frozen", sio_pkg::OFS_LATCH, 16'hFFFF, 16'h0032);
    $display("test hold done");
  endtask : t_hold

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_port();
    t_periph();
    t_odc();
    t_cn();
    t_pullup();
    t_sleep();
    t_remap();
    t_hold();
    give_verdict();
  end
endmodule : tb_top
